/* verilog/fes_pkg.sv */
// Constants and types shared by the flash embedded operation sequencer
`default_nettype none

package fes_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WIN_TIME_US   = 80;
    localparam int PROG_TIME_US  = 8;
    localparam int LIMIT_TIME_US = 10000;
    localparam int PROG_CYC      = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIN_CYC       = (WIN_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int LIMIT_CYC     = (LIMIT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int TMR_W         = 24;

    // ----------------------------------------------------------------
    // Command bytes and unlock addresses (flash byte address, low 16 bits)
    // ----------------------------------------------------------------
    localparam logic [7:0]  CMD_RESET       = 8'hf0;
    localparam logic [7:0]  CMD_UNLOCK1     = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK2     = 8'h55;
    localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
    localparam logic [7:0]  CMD_BLOCK_ERASE = 8'h30;
    localparam logic [15:0] ADDR_UNLOCK1    = 16'haaaa;
    localparam logic [15:0] ADDR_UNLOCK2    = 16'h5554;

    // ----------------------------------------------------------------
    // Status byte layout and data patterns
    // ----------------------------------------------------------------
    localparam int          BIT_DATA_POLL   = 7;
    localparam int          BIT_TOGGLE      = 6;
    localparam int          BIT_TIME_LIMIT  = 5;
    localparam int          BIT_ERASE_WIN   = 3;
    localparam int          NUM_BLOCKS      = 7;
    localparam logic [15:0] ERASED_WORD     = 16'hffff;
    localparam logic [15:0] PREPROG_WORD    = 16'h0000;

    typedef enum logic [10:0] {
        ST_READ    = 11'h001,
        ST_UNLK1   = 11'h002,
        ST_UNLK2   = 11'h004,
        ST_PGM_ARM = 11'h008,
        ST_ERS3    = 11'h010,
        ST_ERS4    = 11'h020,
        ST_ERS5    = 11'h040,
        ST_BLK_WIN = 11'h080,
        ST_PROG    = 11'h100,
        ST_ERASE   = 11'h200,
        ST_FAIL    = 11'h400
    } fes_state_t;

endpackage

`default_nettype wire

/* verilog/fes_sequencer.sv */
// Flash embedded operation sequencer with AHB-Lite array port
//
// Local design decisions: the AHB-Lite interface to the array and the status byte read on it while busy.
`timescale 1ns/1ps
`default_nettype none

module fes_sequencer
    import fes_pkg::*;
#(
    parameter int                   AW        = 17,
    parameter logic [TMR_W-1:0]     WIN_CYCLES   = TMR_W'(fes_pkg::WIN_CYC),
    parameter logic [TMR_W-1:0]     LIMIT_CYCLES = TMR_W'(fes_pkg::LIMIT_CYC)
)
(
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    output logic                    ready_busy_pin
);
    import fes_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        fes_state_t              state;
        logic                    wr_pend;
        logic [AW-1:0]           wa;
        logic [14:0]             ca;
        logic                    stat_sel;
        logic [7:0]              stat;
        logic                    toggle;
        logic                    failed;
        logic                    is_erase;
        logic                    erasing;
        logic [NUM_BLOCKS-1:0]   blk_sel;
        logic [AW-1:0]           pa;
        logic [15:0]             pd;
        logic [TMR_W-1:0]        tmr;
        logic [TMR_W-1:0]        cnt;
        logic [AW-1:0]           ea;
        logic                    pass;
    } fes_regs_t;

    fes_regs_t                   s_ff;
    fes_regs_t                   nxt_s;

    logic [15:0]                 mem [0:(1 << AW) - 1];
    logic [15:0]                 rd_q_ff;
    logic [15:0]                 old_q_ff;
    logic                        mem_we;
    logic [AW-1:0]               mem_wa;
    logic [15:0]                 mem_wd;

    logic                        acc;
    logic                        wr_now;
    logic [7:0]                  cb;
    logic [15:0]                 cadr;
    logic                        busy;
    logic                        bad;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Block select from flash byte address bits 17..13
    function automatic logic [NUM_BLOCKS-1:0] blk_mask(input logic [4:0] a);
        logic [NUM_BLOCKS-1:0] m;
        m = '0;
        casez (a)
            5'b00???: m[0] = 1'b1;
            5'b01???: m[1] = 1'b1;
            5'b10???: m[2] = 1'b1;
            5'b110??: m[3] = 1'b1;
            5'b11100: m[4] = 1'b1;
            5'b11101: m[5] = 1'b1;
            default:  m[6] = 1'b1;
        endcase
        return m;
    endfunction

    function automatic logic is_unlock(input logic [15:0] adr, input logic [7:0] d,
                                       input logic [15:0] want_a, input logic [7:0] want_d);
        return (adr == want_a) && (d == want_d);
    endfunction

    assign acc    = hsel && htrans[1] && hready;
    assign wr_now = s_ff.wr_pend;
    assign cb     = hwdata[7:0];
    // Own 15-bit command index, so unlock decode works with a small array
    assign cadr   = {s_ff.ca, 1'b0};
    assign busy   = (s_ff.state == ST_PROG) || (s_ff.state == ST_ERASE) ||
                    (s_ff.state == ST_FAIL) || (s_ff.state == ST_BLK_WIN);
    // A zero cell asked to become one can never verify
    assign bad    = |(~old_q_ff & s_ff.pd);

    // ----------------------------------------------------------------
    // Array
    // ----------------------------------------------------------------
    // Contents are not reset; an unwritten array reads undefined
    always_ff @(posedge hclk)
    begin
        if (mem_we)
        begin
            mem[mem_wa] <= mem_wd;
        end
        rd_q_ff  <= mem[haddr[AW+1:2]];
        old_q_ff <= mem[s_ff.pa];
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_s  = s_ff;
        mem_we = 1'b0;
        mem_wa = s_ff.pa;
        mem_wd = s_ff.pd & old_q_ff;

        nxt_s.wr_pend = acc && hwrite && (hsize == 3'b010);
        if (acc)
        begin
            nxt_s.wa = haddr[AW+1:2];
            nxt_s.ca = haddr[16:2];
        end
        if (acc && !hwrite)
        begin
            nxt_s.stat_sel = busy;
            nxt_s.stat     = 8'h00;
            nxt_s.stat[BIT_DATA_POLL]  = s_ff.is_erase ? 1'b0 : ~s_ff.pd[7];
            nxt_s.stat[BIT_TOGGLE]     = s_ff.toggle;
            nxt_s.stat[BIT_TIME_LIMIT] = s_ff.failed;
            nxt_s.stat[BIT_ERASE_WIN]  = s_ff.erasing;
            if (busy)
            begin
                nxt_s.toggle = ~s_ff.toggle;
            end
        end

        case (s_ff.state)
            ST_READ:
            begin
                if (wr_now && is_unlock(cadr, cb, ADDR_UNLOCK1, CMD_UNLOCK1))
                begin
                    nxt_s.state = ST_UNLK1;
                end
            end
            ST_UNLK1:
            begin
                if (wr_now)
                begin
                    nxt_s.state = is_unlock(cadr, cb, ADDR_UNLOCK2, CMD_UNLOCK2) ?
                                  ST_UNLK2 : ST_READ;
                end
            end
            ST_UNLK2:
            begin
                if (wr_now)
                begin
                    if (is_unlock(cadr, cb, ADDR_UNLOCK1, CMD_PROGRAM))
                    begin
                        nxt_s.state = ST_PGM_ARM;
                    end
                    else if (is_unlock(cadr, cb, ADDR_UNLOCK1, CMD_ERASE_SETUP))
                    begin
                        nxt_s.state = ST_ERS3;
                    end
                    else
                    begin
                        nxt_s.state = ST_READ;
                    end
                end
            end
            ST_PGM_ARM:
            begin
                if (wr_now)
                begin
                    nxt_s.state    = ST_PROG;
                    nxt_s.pa       = s_ff.wa;
                    nxt_s.pd       = hwdata[15:0];
                    nxt_s.is_erase = 1'b0;
                    nxt_s.erasing  = 1'b0;
                    nxt_s.cnt      = '0;
                    nxt_s.tmr      = '0;
                end
            end
            ST_ERS3:
            begin
                if (wr_now)
                begin
                    nxt_s.state = is_unlock(cadr, cb, ADDR_UNLOCK1, CMD_UNLOCK1) ?
                                  ST_ERS4 : ST_READ;
                end
            end
            ST_ERS4:
            begin
                if (wr_now)
                begin
                    nxt_s.state = is_unlock(cadr, cb, ADDR_UNLOCK2, CMD_UNLOCK2) ?
                                  ST_ERS5 : ST_READ;
                end
            end
            ST_ERS5:
            begin
                nxt_s.is_erase = 1'b1;
                nxt_s.cnt      = '0;
                nxt_s.tmr      = '0;
                nxt_s.ea       = '0;
                nxt_s.pass     = 1'b0;
                nxt_s.pd       = PREPROG_WORD;
                if (wr_now && is_unlock(cadr, cb, ADDR_UNLOCK1, CMD_CHIP_ERASE))
                begin
                    nxt_s.state   = ST_ERASE;
                    nxt_s.blk_sel = '1;
                    nxt_s.erasing = 1'b1;
                end
                else if (wr_now && (cb == CMD_BLOCK_ERASE))
                begin
                    nxt_s.state   = ST_BLK_WIN;
                    nxt_s.blk_sel = blk_mask(s_ff.wa[AW-1 -: 5]);
                    nxt_s.erasing = 1'b0;
                end
                else if (wr_now)
                begin
                    nxt_s.state   = ST_READ;
                end
            end
            ST_BLK_WIN:
            begin
                if (wr_now && (cb == CMD_BLOCK_ERASE))
                begin
                    nxt_s.blk_sel = s_ff.blk_sel | blk_mask(s_ff.wa[AW-1 -: 5]);
                    nxt_s.cnt     = '0;
                end
                else if (wr_now)
                begin
                    nxt_s.state   = ST_READ;
                end
                else if (s_ff.cnt >= WIN_CYCLES - TMR_W'(1))
                begin
                    nxt_s.state   = ST_ERASE;
                    nxt_s.erasing = 1'b1;
                end
                else
                begin
                    nxt_s.cnt     = s_ff.cnt + TMR_W'(1);
                end
            end
            ST_PROG:
            begin
                nxt_s.tmr = s_ff.tmr + TMR_W'(1);
                if (s_ff.cnt < TMR_W'(PROG_CYC - 1))
                begin
                    nxt_s.cnt = s_ff.cnt + TMR_W'(1);
                end
                if (s_ff.tmr >= LIMIT_CYCLES - TMR_W'(1))
                begin
                    nxt_s.state   = ST_FAIL;
                    nxt_s.failed  = 1'b1;
                    nxt_s.erasing = 1'b1;
                end
                else if ((s_ff.cnt >= TMR_W'(PROG_CYC - 1)) && !bad)
                begin
                    mem_we      = 1'b1;
                    nxt_s.state = ST_READ;
                end
            end
            ST_ERASE:
            begin
                nxt_s.tmr = s_ff.tmr + TMR_W'(1);
                mem_wa    = s_ff.ea;
                mem_wd    = s_ff.pass ? ERASED_WORD : PREPROG_WORD;
                mem_we    = |(s_ff.blk_sel & blk_mask(s_ff.ea[AW-1 -: 5]));
                if (s_ff.tmr >= LIMIT_CYCLES - TMR_W'(1))
                begin
                    mem_we       = 1'b0;
                    nxt_s.state  = ST_FAIL;
                    nxt_s.failed = 1'b1;
                end
                else
                begin
                    nxt_s.ea = s_ff.ea + AW'(1);
                    if (&s_ff.ea)
                    begin
                        nxt_s.pass = 1'b1;
                        if (s_ff.pass)
                        begin
                            nxt_s.state = ST_READ;
                        end
                    end
                end
            end
            ST_FAIL:
            begin
                if (wr_now && (cb == CMD_RESET))
                begin
                    nxt_s.state = ST_READ;
                end
            end
            default:
            begin
                nxt_s.state = ST_READ;
            end
        endcase

        if (nxt_s.state == ST_READ)
        begin
            nxt_s.failed  = 1'b0;
            nxt_s.erasing = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_ff       <= '0;
            s_ff.state <= ST_READ;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // Zero wait states; the array is read every cycle so no stall is needed
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign hrdata         = s_ff.stat_sel ? {24'h000000, s_ff.stat} : {16'h0000, rd_q_ff};
    assign ready_busy_pin = (s_ff.state != ST_PROG) && (s_ff.state != ST_ERASE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb_chk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_fail_lock;
        (s_ff.state == ST_FAIL) && !(wr_now && cb == CMD_RESET) |=> s_ff.state == ST_FAIL;
    endproperty
    a_fail_lock: assert property (p_fail_lock) else $error("fail state left without reset");

    property p_fail_reset;
        (s_ff.state == ST_FAIL) && wr_now && (cb == CMD_RESET) |=> s_ff.state == ST_READ;
    endproperty
    a_fail_reset: assert property (p_fail_reset) else $error("reset did not recover");

    property p_seq_abort;
        wr_now && (cb == CMD_RESET) && (s_ff.state inside {ST_UNLK1, ST_UNLK2, ST_ERS3,
            ST_ERS4, ST_ERS5}) |=> s_ff.state == ST_READ;
    endproperty
    a_seq_abort: assert property (p_seq_abort) else $error("reset did not cancel sequence");

    property p_prog_capture;
        (s_ff.state == ST_PGM_ARM) && wr_now |=>
            (s_ff.state == ST_PROG) && (s_ff.pd == $past(hwdata[15:0]));
    endproperty
    a_prog_capture: assert property (p_prog_capture) else $error("program capture wrong");

    property p_busy_ignore;
        (s_ff.state inside {ST_PROG, ST_ERASE}) && wr_now |=>
            $stable(s_ff.pd) && $stable(s_ff.blk_sel) && (s_ff.state != ST_UNLK1);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("write taken while busy");

    property p_win_abort;
        (s_ff.state == ST_BLK_WIN) && wr_now && (cb != CMD_BLOCK_ERASE) |=>
            s_ff.state == ST_READ;
    endproperty
    a_win_abort: assert property (p_win_abort) else $error("window not aborted");

    property p_win_restart;
        (s_ff.state == ST_BLK_WIN) && wr_now && (cb == CMD_BLOCK_ERASE) |=>
            (s_ff.state == ST_BLK_WIN) && (s_ff.cnt == '0) ##1 (s_ff.cnt == TMR_W'(1));
    endproperty
    a_win_restart: assert property (p_win_restart) else $error("window not restarted");

    property p_erase_win_bit;
        ((s_ff.state == ST_BLK_WIN) |-> !s_ff.erasing) and
        ((s_ff.state == ST_ERASE) |-> s_ff.erasing);
    endproperty
    a_erase_win_bit: assert property (p_erase_win_bit) else $error("erase window bit wrong");

    property p_toggle;
        acc && !hwrite && busy |=> s_ff.stat_sel && (s_ff.toggle != $past(s_ff.toggle));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle bit did not flip");

    property p_erase_poll;
        acc && !hwrite && busy && s_ff.is_erase |=> !hrdata[BIT_DATA_POLL];
    endproperty
    a_erase_poll: assert property (p_erase_poll) else $error("erase poll bit not zero");

endmodule

`default_nettype wire

/* test/fes_cpu_model.sv */
// CPU-side model: single word transfers on the AHB-Lite array port
`timescale 1ns/1ps
`default_nettype none

module fes_cpu_model
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0;
    end

    // ------------------------------------------------------------
    // One transfer: address phase, then data phase, both held to hready
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        // Reads get a changing pattern so stale data is never mistaken
        hwdata <= w ? d : ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule

`default_nettype wire

/* test/tb_fes_sequencer.sv */
// Self-checking bench for the flash embedded operation sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_fes_sequencer;
    import fes_pkg::*;
    localparam int          LIM = 3000;
    localparam logic [31:0] U1  = 32'h0001_5554;
    localparam logic [31:0] U2  = 32'h0000_aaa8;
    localparam logic [31:0] PA  = 32'h0000_0040;
    localparam logic [31:0] BA  = 32'h0000_0e00;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel, hwrite, hreadyout, hresp, rdy;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q, p;
    int          err_count = 0;
    int          total_checks = 0;

    always #5 hclk = ~hclk;

    // Small address space keeps a full chip erase short
    fes_sequencer #(.AW(10), .WIN_CYCLES(24'd20), .LIMIT_CYCLES(24'(LIM))) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ready_busy_pin(rdy));

    fes_cpu_model cpu (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        cpu.xfer(1'b1, a, {16'h0, d}, q);
    endtask

    task automatic rd(input logic [31:0] a);
        cpu.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic cmd(input logic [7:0] c, input logic [31:0] a);
        wr(U1, {8'h0, CMD_UNLOCK1});
        wr(U2, {8'h0, CMD_UNLOCK2});
        wr(a, {8'h0, c});
    endtask

    // Status bits polling, time limit and erase window, previous read kept
    task automatic sts(input logic [31:0] a, input logic [2:0] e);
        p = q;
        rd(a);
        chk({29'h0, q[7], q[5], q[3]}, {29'h0, e});
    endtask

    task automatic poll(input logic [31:0] a, m, v);
        int n;
        n = 0;
        do
        begin
            rd(a);
            n++;
        end
        while ((q & m) !== v && n < 40000);
        chk(q & m, v);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        #200000;
        err_count++;
        report_and_stop;
    end

    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({30'h0, hresp, rdy}, 32'h1);
        cmd(CMD_ERASE_SETUP, U1);
        cmd(CMD_CHIP_ERASE, U1);
        sts(PA, 3'b001);
        chk({31'h0, rdy}, 32'h0);
        wr(PA, {8'h0, CMD_RESET});
        sts(PA, 3'b001);
        chk({31'h0, q[6] ^ p[6]}, 32'h1);
        poll(PA, 32'hffff_ffff, 32'h0000_ffff);
        $display("chip erase test done");
        cmd(CMD_PROGRAM, U1);
        wr(PA, 16'h1234);
        sts(PA, 3'b100);
        sts(PA, 3'b100);
        chk({31'h0, q[6] ^ p[6]}, 32'h1);
        poll(PA, 32'hffff_ffff, 32'h0000_1234);
        $display("program test done");
        for (int i = 0; i < 2; i++)
        begin
            wr(U1, {8'h0, CMD_UNLOCK1});
            wr(U2, {8'h0, ((i == 0) ? CMD_RESET : 8'h77)});
            wr(U2, {8'h0, CMD_UNLOCK2});
            wr(U1, {8'h0, CMD_PROGRAM});
            wr(PA, 16'h0000);
            rd(PA);
            chk(q, 32'h0000_1234);
        end
        $display("sequence abort test done");
        cmd(CMD_ERASE_SETUP, U1);
        cmd(CMD_BLOCK_ERASE, BA);
        sts(BA, 3'b000);
        repeat (12) @(posedge hclk);
        wr(BA, {8'h0, CMD_BLOCK_ERASE});
        repeat (12) @(posedge hclk);
        sts(BA, 3'b000);
        wr(PA, 16'h0050);
        rd(PA);
        chk(q, 32'h0000_1234);
        $display("erase window abort test done");
        cmd(CMD_PROGRAM, U1);
        wr(PA, 16'hffff);
        sts(PA, 3'b000);
        poll(PA, 32'h0000_0020, 32'h0000_0020);
        sts(PA, 3'b011);
        sts(PA, 3'b011);
        chk({31'h0, q[6] ^ p[6]}, 32'h1);
        cmd(CMD_PROGRAM, U1);
        sts(PA, 3'b011);
        wr(U1, {8'h0, CMD_RESET});
        rd(PA);
        chk(q, 32'h0000_1234);
        $display("program failure test done");
        cmd(CMD_ERASE_SETUP, U1);
        cmd(CMD_BLOCK_ERASE, BA);
        poll(BA, 32'h0000_0008, 32'h0000_0008);
        sts(BA, 3'b001);
        chk({31'h0, rdy}, 32'h0);
        poll(BA, 32'hffff_ffff, 32'h0000_ffff);
        rd(PA);
        chk(q, 32'h0000_1234);
        $display("erase window expiry test done");
        report_and_stop;
    end
endmodule

`default_nettype wire
